// ==== design/nav_state_packet_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module nav_state_packet_formatter (
  input  wire logic                       clk_in,
  input  wire logic                       rstn_in,
  input  wire nav_fmt_pkg::nav_solution_t sol_in,
  input  wire logic                       sol_valid_in,
  input  wire logic [9:0]                 pkt_enable_in,
  output logic                            sol_ready_out,
  output nav_fmt_pkg::byte_beat_t         beat_out,
  output logic                            beat_valid_out,
  input  wire logic                       beat_ready_in,
  output logic [7:0]                      pkt_len_out,
  output logic                            busy_out
);
  import nav_fmt_pkg::*;

  // ************************************************************
  // payload builder
  // ************************************************************
  // little-endian packing
  function automatic logic [8*PAYLOAD_MAX-1:0] put(input logic [8*PAYLOAD_MAX-1:0] buf_in,
      input int ofs, input logic [63:0] val, input int nbytes);
    logic [8*PAYLOAD_MAX-1:0] b;
    b = buf_in;
    for (int i = 0; i < 8; i++) begin
      if (i < nbytes) begin
        b[8*(ofs+i) +: 8] = val[8*i +: 8];
      end
    end
    return b;
  endfunction

  function automatic logic [7:0] len_of(input int k);
    case (k)
      0: return LEN_GEODETIC;
      1: return LEN_ECEF;
      2: return LEN_GRID;
      6: return LEN_BODY_ACC;
      8: return LEN_QUAT;
      9: return LEN_DCM;
      default: return LEN_VEC3;
    endcase
  endfunction

  function automatic logic [7:0] id_of(input int k);
    case (k)
      0: return ID_GEODETIC;
      1: return ID_ECEF;
      2: return ID_GRID;
      3: return ID_NED_VEL;
      4: return ID_BODY_VEL;
      5: return ID_ACCEL;
      6: return ID_BODY_ACC;
      7: return ID_EULER;
      8: return ID_QUAT;
      default: return ID_DCM;
    endcase
  endfunction

  nav_solution_t            epoch_ff;
  fmt_state_t               state_ff;
  logic [3:0]               pkt_ff;
  logic [7:0]               idx_ff;
  logic [9:0]               pend_ff;
  logic [8*PAYLOAD_MAX-1:0] payload;
  logic                     take;
  logic                     beat_last;

  always_comb begin
    payload = '0;
    case (pkt_ff)
      4'h0: begin
        payload = put(payload, 0, epoch_ff.lat, 8);
        payload = put(payload, 8, epoch_ff.lon, 8);
        payload = put(payload, 16, epoch_ff.hgt, 8);
      end
      4'h1: begin
        payload = put(payload, 0, epoch_ff.ecef_x, 8);
        payload = put(payload, 8, epoch_ff.ecef_y, 8);
        payload = put(payload, 16, epoch_ff.ecef_z, 8);
      end
      4'h2: begin
        payload = put(payload, 0, epoch_ff.northing, 8);
        payload = put(payload, 8, epoch_ff.easting, 8);
        payload = put(payload, 16, epoch_ff.grid_hgt, 8);
        payload = put(payload, int'(OFS_ZONE_NUM), {56'h0, epoch_ff.zone_num}, 1);
        payload = put(payload, int'(OFS_ZONE_CHAR), {56'h0, epoch_ff.zone_char}, 1);
      end
      4'h3: begin
        for (int i = 0; i < 3; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.ned_vel[i]}, 4);
      end
      4'h4: begin
        for (int i = 0; i < 3; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.body_vel[i]}, 4);
      end
      4'h5: begin
        for (int i = 0; i < 3; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.accel[i]}, 4);
      end
      4'h6: begin
        for (int i = 0; i < 3; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.body_acc[i]}, 4);
        payload = put(payload, 12, {32'h0, epoch_ff.load_g}, 4);
      end
      4'h7: begin
        for (int i = 0; i < 3; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.euler[i]}, 4);
      end
      4'h8: begin
        payload = put(payload, 0, {32'h0, epoch_ff.quat_scalar_part}, 4);
        payload = put(payload, 4, {32'h0, epoch_ff.quat_x_part}, 4);
        payload = put(payload, 8, {32'h0, epoch_ff.quat_y_part}, 4);
        payload = put(payload, 12, {32'h0, epoch_ff.quat_z_part}, 4);
      end
      4'h9: begin
        for (int i = 0; i < 9; i++) payload = put(payload, 4*i, {32'h0, epoch_ff.rot[i]}, 4);
      end
      default: payload = '0;
    endcase
  end

  // ************************************************************
  // epoch capture and sequencing
  // ************************************************************
  assign sol_ready_out  = (state_ff == ST_IDLE);
  assign take           = sol_ready_out && sol_valid_in && (pkt_enable_in != 10'h000);
  assign beat_valid_out = (state_ff == ST_SEND);
  assign beat_last      = (idx_ff == len_of(int'(pkt_ff)) - 8'h01);
  assign busy_out       = (state_ff != ST_IDLE);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      epoch_ff <= '0;
    end else if (take) begin
      epoch_ff <= sol_in;
    end
  end

  function automatic logic [3:0] first_set(input logic [9:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_PACKETS - 1; i >= 0; i--) begin
      if (m[i]) r = 4'(i);
    end
    return r;
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_ff <= ST_IDLE;
      pkt_ff   <= 4'h0;
      idx_ff   <= 8'h00;
      pend_ff  <= 10'h000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            pend_ff  <= pkt_enable_in;
            pkt_ff   <= first_set(pkt_enable_in);
            idx_ff   <= 8'h00;
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (beat_ready_in) begin
            if (beat_last) begin
              pend_ff[pkt_ff] <= 1'b0;
              state_ff        <= ST_NEXT;
            end else begin
              idx_ff <= idx_ff + 8'h01;
            end
          end
        end
        ST_NEXT: begin
          idx_ff <= 8'h00;
          if (pend_ff == 10'h000) begin
            state_ff <= ST_IDLE;
          end else begin
            pkt_ff   <= first_set(pend_ff);
            state_ff <= ST_SEND;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // data straight from the epoch register, indexed by the byte counter
  always_comb begin
    beat_out.data  = payload[8*idx_ff +: 8];
    beat_out.id    = id_of(int'(pkt_ff));
    beat_out.index = idx_ff;
    beat_out.first = (idx_ff == 8'h00);
    beat_out.last  = beat_last;
    pkt_len_out    = len_of(int'(pkt_ff));
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_epoch_held_stable: assert property (@(posedge clk_in) disable iff (!rstn_in)
    busy_out && !take |=> $stable(epoch_ff))
    else $error("epoch changed mid packet");
  a_grid_zone_bytes: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.id == ID_GRID && beat_out.index == OFS_ZONE_CHAR
      |-> beat_out.data == epoch_ff.zone_char && beat_out.last)
    else $error("zone letter misplaced");
  a_geo_length_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.last && beat_out.id == ID_GEODETIC |-> beat_out.index == 8'h17)
    else $error("geodetic length wrong");
  a_ecef_lsb_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.id == ID_ECEF && beat_out.first
      |-> beat_out.data == epoch_ff.ecef_x[7:0])
    else $error("ecef not lsb first");
  a_quat_scalar_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.id == ID_QUAT && beat_out.first
      |-> beat_out.data == epoch_ff.quat_scalar_part[7:0])
    else $error("quaternion order wrong");
  a_dcm_length_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.last && beat_out.id == ID_DCM |-> beat_out.index == 8'h23)
    else $error("matrix length wrong");
  a_load_factor_pos: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.id == ID_BODY_ACC && beat_out.index == 8'h0c
      |-> beat_out.data == epoch_ff.load_g[7:0])
    else $error("load factor misplaced");
  a_vec_length_ok: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && beat_out.last && beat_out.id == ID_NED_VEL |-> beat_out.index == 8'h0b)
    else $error("velocity length wrong");
  a_beat_held_stall: assert property (@(posedge clk_in) disable iff (!rstn_in)
    beat_valid_out && !beat_ready_in |=> beat_valid_out && $stable(beat_out))
    else $error("beat dropped under stall");
endmodule
`default_nettype wire

// ==== design/nav_fmt_pkg.sv ====
// Function
// - geodetic position goes out as id 32, 24 bytes: latitude, longitude, height as fp64 at 0, 8, 16.
// - earth-centred position goes out as id 33, 24 bytes: x, y, z as fp64 in that order.
// - grid-zone position goes out as id 34, 26 bytes, opening with northing, easting, height fp64.
// - grid-zone zone number is an unsigned byte at 24 and zone letter a signed byte at 25.
// - north-east-down velocity goes out as id 35, 12 bytes of three fp32.
// - body-frame velocity goes out as id 36, 12 bytes: x, y, z fp32 at 0, 4, 8.
// - acceleration with gravity goes out as id 37, 12 bytes of three fp32.
// - body acceleration without gravity goes out as id 38, 16 bytes, load factor at 12.
// - euler orientation goes out as id 39, 12 bytes: roll, pitch, heading fp32.
// - quaternion goes out as id 40, 16 bytes: scalar, then x, y, z fp32.
// - rotation matrix goes out as id 41, 36 bytes: nine fp32 row-major at 4-byte steps.
package nav_fmt_pkg;
  // ************************************************************
  // packet identifiers and payload lengths
  // ************************************************************
  localparam logic [7:0] ID_GEODETIC = 8'h20;
  localparam logic [7:0] ID_ECEF     = 8'h21;
  localparam logic [7:0] ID_GRID     = 8'h22;
  localparam logic [7:0] ID_NED_VEL  = 8'h23;
  localparam logic [7:0] ID_BODY_VEL = 8'h24;
  localparam logic [7:0] ID_ACCEL    = 8'h25;
  localparam logic [7:0] ID_BODY_ACC = 8'h26;
  localparam logic [7:0] ID_EULER    = 8'h27;
  localparam logic [7:0] ID_QUAT     = 8'h28;
  localparam logic [7:0] ID_DCM      = 8'h29;
  localparam logic [7:0] LEN_GEODETIC = 8'h18;
  localparam logic [7:0] LEN_ECEF     = 8'h18;
  localparam logic [7:0] LEN_GRID     = 8'h1a;
  localparam logic [7:0] LEN_VEC3     = 8'h0c;
  localparam logic [7:0] LEN_BODY_ACC = 8'h10;
  localparam logic [7:0] LEN_QUAT     = 8'h10;
  localparam logic [7:0] LEN_DCM      = 8'h24;
  localparam logic [7:0] OFS_ZONE_NUM  = 8'h18;
  localparam logic [7:0] OFS_ZONE_CHAR = 8'h19;
  localparam int         PAYLOAD_MAX   = 36;
  localparam int         NUM_PACKETS   = 10;

  typedef struct packed {
    logic [63:0] lat;
    logic [63:0] lon;
    logic [63:0] hgt;
    logic [63:0] ecef_x;
    logic [63:0] ecef_y;
    logic [63:0] ecef_z;
    logic [63:0] northing;
    logic [63:0] easting;
    logic [63:0] grid_hgt;
    logic [7:0]  zone_num;
    logic [7:0]  zone_char;
    logic [2:0][31:0] ned_vel;
    logic [2:0][31:0] body_vel;
    logic [2:0][31:0] accel;
    logic [2:0][31:0] body_acc;
    logic [31:0] load_g;
    logic [2:0][31:0] euler;
    logic [31:0] quat_scalar_part;
    logic [31:0] quat_x_part;
    logic [31:0] quat_y_part;
    logic [31:0] quat_z_part;
    logic [8:0][31:0] rot;
  } nav_solution_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] id;
    logic [7:0] index;
    logic       first;
    logic       last;
  } byte_beat_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_NEXT = 2'b11
  } fmt_state_t;
endpackage

// ==== verif/nav_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// host side sink: takes beats, stalls at random when asked
// ************************************************************
module nav_sink_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic stall_in,
  output logic      ready_out
);
  integer seed = 17;
  integer r;

  // ready is a level; a stalling host must not be kinder than a real one
  always @(posedge clk_in) begin
    r = $random(seed);
    if (!rstn_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= stall_in ? r[0] & r[3] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/nav_state_packet_formatter_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module nav_state_packet_formatter_tb_top;
  import nav_fmt_pkg::*;
  logic          clk_in = 0, rstn_in = 0, sol_valid_in = 0, stall = 0;
  logic          beat_ready_in, sol_ready_out, beat_valid_out, busy_out;
  nav_solution_t sol_in = '0;
  logic [9:0]    pkt_enable_in = '0;
  byte_beat_t    beat_out;
  logic [7:0]    pkt_len_out;
  byte_beat_t    exp_q[$];
  logic [7:0]    len_q[$];
  logic [7:0]    lens[10] = '{8'h18, 8'h18, 8'h1a, 8'h0c, 8'h0c, 8'h0c, 8'h10, 8'h0c, 8'h10, 8'h24};
  integer        seed = 29;
  int            n_mismatch = 0, tests_run = 0, i;

  always #50 clk_in = ~clk_in;

  nav_state_packet_formatter dut (.clk_in(clk_in), .rstn_in(rstn_in), .sol_in(sol_in),
    .sol_valid_in(sol_valid_in), .pkt_enable_in(pkt_enable_in), .sol_ready_out(sol_ready_out),
    .beat_out(beat_out), .beat_valid_out(beat_valid_out), .beat_ready_in(beat_ready_in),
    .pkt_len_out(pkt_len_out), .busy_out(busy_out));
  nav_sink_model sink (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(stall),
    .ready_out(beat_ready_in));

  // ************************************************************
  // comparison and closing
  // ************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // expected payloads, built field by field, low byte first
  // ************************************************************
  function automatic nav_solution_t rnd_sol();
    logic [1535:0] t;
    for (int j = 0; j < 48; j++) t[32*j +: 32] = $random(seed);
    return t[$bits(nav_solution_t)-1:0];
  endfunction

  task automatic put(ref logic [7:0] b[$], input logic [63:0] v, input int n);
    for (int j = 0; j < n; j++) b.push_back(v[8*j +: 8]);
  endtask

  task automatic push_pkt(input int k, input nav_solution_t s);
    logic [7:0]       b[$];
    logic [2:0][31:0] v;
    v = k == 3 ? s.ned_vel : k == 4 ? s.body_vel : k == 5 ? s.accel : k == 6 ? s.body_acc : s.euler;
    case (k)
      0: begin put(b, s.lat, 8); put(b, s.lon, 8); put(b, s.hgt, 8); end
      1: begin put(b, s.ecef_x, 8); put(b, s.ecef_y, 8); put(b, s.ecef_z, 8); end
      2: begin
        put(b, s.northing, 8); put(b, s.easting, 8); put(b, s.grid_hgt, 8);
        put(b, s.zone_num, 1); put(b, s.zone_char, 1);
      end
      8: begin
        put(b, s.quat_scalar_part, 4); put(b, s.quat_x_part, 4);
        put(b, s.quat_y_part, 4); put(b, s.quat_z_part, 4);
      end
      9: for (int j = 0; j < 9; j++) put(b, s.rot[j], 4);
      default: begin
        for (int j = 0; j < 3; j++) put(b, v[j], 4);
        if (k == 6) put(b, s.load_g, 4);
      end
    endcase
    for (int j = 0; j < b.size(); j++) begin
      exp_q.push_back('{b[j], 8'(8'h20 + k), 8'(j), j == 0, j == b.size() - 1});
      len_q.push_back(lens[k]);
    end
  endtask

  // offers one epoch; inputs are scrambled right after the take
  task automatic send(input logic [9:0] m);
    int w;
    @(posedge clk_in);
    sol_in <= rnd_sol();
    pkt_enable_in <= m;
    sol_valid_in <= 1'b1;
    @(negedge clk_in);
    for (w = 0; w < 3000 && sol_ready_out !== 1'b1; w++) @(negedge clk_in);
    if (w == 3000) begin n_mismatch++; test_done(); end
    for (int k = 0; k < 10; k++) if (m[k]) push_pkt(k, sol_in);
    @(posedge clk_in);
    sol_valid_in <= 1'b0;
    sol_in <= rnd_sol();
    pkt_enable_in <= 10'($random(seed));
  endtask

  // ************************************************************
  // monitor: each accepted beat takes the oldest note
  // ************************************************************
  always @(posedge clk_in) begin
    if (rstn_in && beat_valid_out === 1'b1 && beat_ready_in === 1'b1) begin
      check(64'(exp_q.size() != 0), 64'h1);
      if (exp_q.size() != 0) begin
        check(64'(beat_out), 64'(exp_q.pop_front()));
        check(64'(pkt_len_out), 64'(len_q.pop_front()));
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    test_done();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check(64'({sol_ready_out, beat_valid_out, busy_out}), 64'h4);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int k = 0; k < 10; k++) send(10'h001 << k);
    stall <= 1'b1;
    send(10'h3ff);
    send(10'h3ff);
    send(10'h000);
    @(negedge clk_in);
    check(64'(busy_out), 64'h0);
    repeat (6) send(10'($random(seed)));
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk_in);
    check(64'(exp_q.size()), 64'h0);
    test_done();
  end
endmodule
`default_nettype wire
